// >>> verilog/sgact_pkg.sv
// package: sizes, register map, timing and the loss output layout of the block
package sgact_pkg;
    // sizes
    localparam int NBITS = 128;
    localparam int NPORTS = 32;
    localparam int NMODS = 65;
    localparam int NSERDES = 8;
    localparam int IDXW = 7;
    // timing: a 1 ms tick from the 100 MHz clock times the envelope
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES_DEF = CLK_HZ / 1_000_000 * TICK_US;
    localparam int ENV_MS = 100;
    // one extra tick because the pulse lands anywhere inside a tick
    localparam int ENV_TICKS = ENV_MS * 1000 / TICK_US + 1;
    // register byte offsets
    localparam logic [11:0] OFS_ENABLE = 12'h000;
    localparam logic [11:0] OFS_RAW = 12'h010;
    localparam logic [11:0] OFS_STICKY = 12'h020;
    localparam logic [11:0] OFS_IDENT = 12'h030;
    localparam logic [11:0] OFS_POL = 12'h040;
    localparam logic [11:0] OFS_TRIG_LO = 12'h050;
    localparam logic [11:0] OFS_TRIG_HI = 12'h060;
    localparam logic [11:0] OFS_SD_CFG = 12'h070;
    localparam logic [11:0] OFS_ACT_SEL = 12'h074;
    localparam logic [11:0] OFS_ACT_POL = 12'h078;
    localparam logic [11:0] OFS_PMAP = 12'h400;
    localparam logic [11:0] OFS_SMAP = 12'h800;
    // signal_detect_config fields and reset
    localparam int SD_HIGH_BIT = 0;
    localparam int SD_MAP_BIT = 1;
    localparam logic [1:0] SD_CFG_RST = 2'h0;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // controller numbering and port-module mapping
    localparam logic [1:0] CTRL_SG1 = 2'h1;
    localparam logic [1:0] CTRL_SG2 = 2'h2;
    localparam logic [IDXW-1:0] MOD_HIGH_BASE = 7'h20;
    localparam logic [IDXW-1:0] MOD_SG2_PORT0 = 7'h40;
    localparam logic [4:0] SG2_HIGH_FIRST = 5'h10;

    // loss-of-signal outputs to port modules and serdes lanes
    typedef struct packed {
        logic [NMODS-1:0] port;
        logic [NSERDES-1:0] serdes;
    } sgact_los_s;

    // port module fed by a serial port of a given controller
    function automatic logic [IDXW-1:0] port_module(input logic [1:0] ctrl,
                                                    input logic [4:0] port);
        logic [IDXW-1:0] p;
        p = {2'h0, port};
        if (ctrl == CTRL_SG1) return p + MOD_HIGH_BASE;
        if (ctrl == CTRL_SG2 && port == 5'h00) return MOD_SG2_PORT0;
        if (ctrl == CTRL_SG2 && port >= SG2_HIGH_FIRST) begin
            return p + MOD_HIGH_BASE;
        end
        return p;
    endfunction : port_module
endpackage : sgact_pkg

// >>> verilog/sgact_envelope.sv
// activity envelope stretcher with its own millisecond prescaler
`timescale 1ns/1ps
module sgact_envelope #(
    parameter int NPORTS = 32,
    parameter int TICK_CYCLES = sgact_pkg::TICK_CYCLES_DEF,
    parameter int ENV_TICKS = sgact_pkg::ENV_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [NPORTS-1:0] act_i,
    output logic [NPORTS-1:0] env_o
);
    localparam int CW = $clog2(TICK_CYCLES);
    localparam int EW = $clog2(ENV_TICKS + 1);

    typedef struct packed {
        logic [CW-1:0] presc;
        logic tick;
        logic [NPORTS-1:0][EW-1:0] cnt;
        logic [NPORTS-1:0] env;
    } sgact_env_s;

    sgact_env_s r_reg;
    sgact_env_s r_next;

    // prescaler tick, then per-port reload or count down
    always_comb begin
        r_next = r_reg;
        r_next.tick = 1'b0;
        r_next.presc = r_reg.presc + 1'b1;
        if (r_reg.presc == CW'(TICK_CYCLES - 1)) begin
            r_next.presc = '0;
            r_next.tick = 1'b1;
        end
        for (int p = 0; p < NPORTS; p++) begin
            if (act_i[p]) begin
                r_next.cnt[p] = EW'(ENV_TICKS);
            end else if (r_reg.tick && r_reg.cnt[p] != '0) begin
                r_next.cnt[p] = r_reg.cnt[p] - 1'b1;
            end
            r_next.env[p] = r_next.cnt[p] != '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) r_reg <= '0;
        else r_reg <= r_next;
    end

    assign env_o = r_reg.env;

    property p_env_reload;
        @(posedge clk_i) disable iff (rst_i)
        act_i[0] |=> r_reg.cnt[0] == EW'(ENV_TICKS);
    endproperty
    a_env_reload: assert property (p_env_reload)
        else $error("envelope not reloaded by activity pulse");

    property p_env_stretch;
        @(posedge clk_i) disable iff (rst_i)
        act_i[0] |=> env_o[0] [*8];
    endproperty
    a_env_stretch: assert property (p_env_stretch)
        else $error("envelope dropped right after activity pulse");
endmodule : sgact_envelope

// >>> verilog/sgact_los_route.sv
// loss-of-signal routing from serial inputs to port modules and serdes
`timescale 1ns/1ps
module sgact_los_route #(
    parameter logic [1:0] CTRL = 2'h0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [sgact_pkg::NBITS-1:0] raw_i,
    input wire logic [1:0] sd_cfg_i,
    input wire logic [sgact_pkg::NMODS-1:0][sgact_pkg::IDXW-1:0] pmap_i,
    input wire logic [sgact_pkg::NSERDES-1:0][sgact_pkg::IDXW-1:0] smap_i,
    input wire logic [sgact_pkg::NMODS-1:0] pgpio_sel_i,
    output sgact_pkg::sgact_los_s los_o
);
    import sgact_pkg::*;

    sgact_los_s r_reg;
    sgact_los_s r_next;
    logic [NMODS-1:0] high_map;
    logic [NMODS-1:0] low_map;

    // fixed mappings: bit 0 of each port, already polarity corrected
    always_comb begin
        high_map = '0;
        low_map = '0;
        for (int p = 0; p < NPORTS; p++) begin
            high_map[port_module(CTRL, 5'(p))] = raw_i[4*p];
            low_map[p] = raw_i[4*p];
        end
    end

    // custom map wins, then high/low choice, overlay masks last
    always_comb begin
        r_next = '0;
        for (int m = 0; m < NMODS; m++) begin
            if (sd_cfg_i[SD_MAP_BIT]) begin
                r_next.port[m] = raw_i[pmap_i[m]];
            end else if (sd_cfg_i[SD_HIGH_BIT]) begin
                r_next.port[m] = high_map[m];
            end else begin
                r_next.port[m] = low_map[m];
            end
            if (pgpio_sel_i[m]) r_next.port[m] = 1'b0;
        end
        for (int s = 0; s < NSERDES; s++) begin
            r_next.serdes[s] = sd_cfg_i[SD_MAP_BIT] & raw_i[smap_i[s]];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) r_reg <= '0;
        else r_reg <= r_next;
    end

    assign los_o = r_reg;

    property p_los_custom;
        @(posedge clk_i) disable iff (rst_i)
        sd_cfg_i[SD_MAP_BIT] && !pgpio_sel_i[2]
            |=> los_o.port[2] == $past(raw_i[pmap_i[2]]);
    endproperty
    a_los_custom: assert property (p_los_custom)
        else $error("custom map not followed for module 2");

    property p_los_overlay;
        @(posedge clk_i) disable iff (rst_i)
        pgpio_sel_i[3] |=> !los_o.port[3];
    endproperty
    a_los_overlay: assert property (p_los_overlay)
        else $error("serial value leaked while overlay selected");
endmodule : sgact_los_route

// >>> verilog/sgact_top.sv
// link activity gating, serial input interrupts and signal detect forwarding
//
// Behaviour
// - ports map to fixed modules; third controller ports 16-31 go to 48-63.
// - activity output follows the blink pattern only while envelope is high.
// - each activity pulse stretches into an envelope of at least 100 ms.
// - a pulse during the envelope extends it by 100 ms from that pulse.
// - a per-port polarity setting selects activity output polarity.
// - the interrupt output is a level, never pulses.
// - each of 128 inputs has enable, raw, sticky and identity bits.
// - raw bit is input corrected by per-bit polarity, following input.
// - sticky bit sets by per-bit trigger: level, any edge, fall or rise.
// - sticky bits hold until software writes one to clear them.
// - identity is sticky AND enable, updating whenever either changes.
// - one interrupt output is high while any identity bit is set.
// - bit 0 of each serial port feeds that port module's loss input.
// - port n feeds module n by default; a bit selects the high mapping.
// - when the parallel overlay supplies loss, the serial value is ignored.
// - a map-select bit routes any input to any module or serdes loss.
// - forwarded loss values use the interrupt polarity setting.
// - gated pattern comes from one of two blink generators outside.
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module sgact_top #(
    parameter logic [1:0] CTRL = 2'h0,
    parameter int TICK_CYCLES = sgact_pkg::TICK_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [sgact_pkg::NBITS-1:0] input_bits_i,
    input wire logic burst_done_i,
    input wire logic blink0_i,
    input wire logic blink1_i,
    input wire logic [sgact_pkg::NMODS-1:0] act_pulse_i,
    input wire logic [sgact_pkg::NMODS-1:0] pgpio_los_sel_i,
    output logic [sgact_pkg::NPORTS-1:0] led_o,
    output logic irq_o,
    output sgact_pkg::sgact_los_s los_o
);
    import sgact_pkg::*;

    typedef struct packed {
        logic [NBITS-1:0] enable;
        logic [NBITS-1:0] polarity;
        logic [NBITS-1:0] trig_lo;
        logic [NBITS-1:0] trig_hi;
        logic [NBITS-1:0] sticky;
        logic [NBITS-1:0] prev;
        logic [1:0] sd_cfg;
        logic [NPORTS-1:0] act_sel;
        logic [NPORTS-1:0] act_pol;
        logic [NPORTS-1:0] led;
        logic [NMODS-1:0][IDXW-1:0] pmap;
        logic [NSERDES-1:0][IDXW-1:0] smap;
        logic [31:0] rdata;
        logic ack;
        logic irq;
    } sgact_main_s;

    sgact_main_s r_reg;
    sgact_main_s r_next;

    logic [NBITS-1:0] raw;
    logic [NBITS-1:0] ident;
    logic [NBITS-1:0] set;
    logic [NBITS-1:0] clr;
    logic [NBITS-1:0] edge_hit;
    logic [NPORTS-1:0] port_pulse;
    logic [NPORTS-1:0] env;
    logic take;
    logic wr;
    logic [7:0] widx;
    logic [1:0] wsub;

    // byte lanes of a write
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
        return (old & ~lane_mask(sel)) | (wd & lane_mask(sel));
    endfunction : merge

    function automatic logic [31:0] word_of(input logic [NBITS-1:0] v,
                                            input logic [1:0] k);
        return v[32*k +: 32];
    endfunction : word_of

    // bus decode; a request is taken once, ack blocks a second take
    assign take = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    assign wr = take & wb_we_i;
    assign widx = wb_adr_i[9:2];
    assign wsub = wb_adr_i[3:2];

    // polarity-corrected input and the enabled view of sticky bits
    assign raw = input_bits_i ^ r_reg.polarity;
    assign ident = r_reg.sticky & r_reg.enable;

    // edges are judged only when a fresh burst has landed
    assign edge_hit = (~r_reg.trig_hi & r_reg.trig_lo & (raw ^ r_reg.prev))
                    | (r_reg.trig_hi & ~r_reg.trig_lo & r_reg.prev & ~raw)
                    | (r_reg.trig_hi & r_reg.trig_lo & ~r_reg.prev & raw);
    assign set = (~r_reg.trig_hi & ~r_reg.trig_lo & raw)
               | ({NBITS{burst_done_i}} & edge_hit);

    // software clear of sticky bits, one 32-bit word at a time
    always_comb begin
        clr = '0;
        if (wr && wb_adr_i[11:4] == OFS_STICKY[11:4]) begin
            clr[32*wsub +: 32] = wb_dat_i & lane_mask(wb_sel_i);
        end
    end

    // activity pulse of the port module behind each serial port
    generate
        for (genvar p = 0; p < NPORTS; p++) begin : g_pulse
            assign port_pulse[p] =
                act_pulse_i[port_module(CTRL, 5'(p))];
        end
    endgenerate

    sgact_envelope #(
        .NPORTS(NPORTS),
        .TICK_CYCLES(TICK_CYCLES),
        .ENV_TICKS(ENV_TICKS)
    ) u_env (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .act_i(port_pulse),
        .env_o(env)
    );

    sgact_los_route #(
        .CTRL(CTRL)
    ) u_los (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(raw),
        .sd_cfg_i(r_reg.sd_cfg),
        .pmap_i(r_reg.pmap),
        .smap_i(r_reg.smap),
        .pgpio_sel_i(pgpio_los_sel_i),
        .los_o(los_o)
    );

    // next state: interrupt core, led gating, register writes and reads
    always_comb begin
        r_next = r_reg;
        r_next.ack = take;
        // set wins over a clear in the same cycle
        r_next.sticky = (r_reg.sticky & ~clr) | set;
        if (burst_done_i) r_next.prev = raw;
        r_next.irq = |ident;
        for (int p = 0; p < NPORTS; p++) begin
            r_next.led[p] = ((r_reg.act_sel[p] ? blink1_i : blink0_i)
                             & env[p]) ^ r_reg.act_pol[p];
        end
        r_next.rdata = UNMAPPED_READ;
        if (take) begin
            case (wb_adr_i[11:4])
                OFS_ENABLE[11:4]: begin
                    r_next.rdata = word_of(r_reg.enable, wsub);
                    if (wr) begin
                        r_next.enable[32*wsub +: 32] =
                            merge(word_of(r_reg.enable, wsub), wb_dat_i,
                                  wb_sel_i);
                    end
                end
                OFS_RAW[11:4]: r_next.rdata = word_of(raw, wsub);
                OFS_STICKY[11:4]: r_next.rdata = word_of(r_reg.sticky, wsub);
                OFS_IDENT[11:4]: r_next.rdata = word_of(ident, wsub);
                OFS_POL[11:4]: begin
                    r_next.rdata = word_of(r_reg.polarity, wsub);
                    if (wr) begin
                        r_next.polarity[32*wsub +: 32] =
                            merge(word_of(r_reg.polarity, wsub), wb_dat_i,
                                  wb_sel_i);
                    end
                end
                OFS_TRIG_LO[11:4]: begin
                    r_next.rdata = word_of(r_reg.trig_lo, wsub);
                    if (wr) begin
                        r_next.trig_lo[32*wsub +: 32] =
                            merge(word_of(r_reg.trig_lo, wsub), wb_dat_i,
                                  wb_sel_i);
                    end
                end
                OFS_TRIG_HI[11:4]: begin
                    r_next.rdata = word_of(r_reg.trig_hi, wsub);
                    if (wr) begin
                        r_next.trig_hi[32*wsub +: 32] =
                            merge(word_of(r_reg.trig_hi, wsub), wb_dat_i,
                                  wb_sel_i);
                    end
                end
                OFS_SD_CFG[11:4]: begin
                    // three small words share this line of the map
                    if (wb_adr_i == OFS_SD_CFG) begin
                        r_next.rdata = {30'h0, r_reg.sd_cfg};
                        if (wr && wb_sel_i[0]) begin
                            r_next.sd_cfg = wb_dat_i[1:0];
                        end
                    end else if (wb_adr_i == OFS_ACT_SEL) begin
                        r_next.rdata = r_reg.act_sel;
                        if (wr) begin
                            r_next.act_sel = merge(r_reg.act_sel, wb_dat_i,
                                                   wb_sel_i);
                        end
                    end else if (wb_adr_i == OFS_ACT_POL) begin
                        r_next.rdata = r_reg.act_pol;
                        if (wr) begin
                            r_next.act_pol = merge(r_reg.act_pol, wb_dat_i,
                                                   wb_sel_i);
                        end
                    end
                end
                default: begin
                    // map tables; holes above the last entry read zero
                    if (wb_adr_i[11:10] == OFS_PMAP[11:10]
                        && widx < 8'(NMODS)) begin
                        r_next.rdata = {25'h0, r_reg.pmap[widx]};
                        if (wr && wb_sel_i[0]) begin
                            r_next.pmap[widx] = wb_dat_i[IDXW-1:0];
                        end
                    end else if (wb_adr_i[11:10] == OFS_SMAP[11:10]
                                 && widx < 8'(NSERDES)) begin
                        r_next.rdata = {25'h0, r_reg.smap[widx[2:0]]};
                        if (wr && wb_sel_i[0]) begin
                            r_next.smap[widx[2:0]] = wb_dat_i[IDXW-1:0];
                        end
                    end
                end
            endcase
        end
    end

    // single state register; reset clears every field
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '0;
            r_reg.sd_cfg <= SD_CFG_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wb_dat_o = r_reg.rdata;
    assign wb_ack_o = r_reg.ack;
    assign led_o = r_reg.led;
    assign irq_o = r_reg.irq;

    // checks of the interrupt path, register views, led gating and single-cycle bus ack
    property p_irq_on;
        @(posedge clk_i) disable iff (rst_i)
        (|ident) |=> irq_o;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("interrupt low while an identity bit is set");

    property p_irq_off;
        @(posedge clk_i) disable iff (rst_i)
        !(|ident) |=> !irq_o;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt high with no identity bit set");

    property p_sticky_hold;
        @(posedge clk_i) disable iff (rst_i)
        !(wr && wb_adr_i[11:4] == OFS_STICKY[11:4])
            |=> (r_reg.sticky & $past(r_reg.sticky)) == $past(r_reg.sticky);
    endproperty
    a_sticky_hold: assert property (p_sticky_hold)
        else $error("sticky bit dropped without a clear write");

    property p_sticky_clear;
        @(posedge clk_i) disable iff (rst_i)
        wr && wb_adr_i == OFS_STICKY && wb_sel_i[0] && wb_dat_i[1] && !set[1]
            |=> !r_reg.sticky[1];
    endproperty
    a_sticky_clear: assert property (p_sticky_clear)
        else $error("write of one did not clear sticky bit");

    property p_rise;
        @(posedge clk_i) disable iff (rst_i)
        burst_done_i && r_reg.trig_hi[0] && r_reg.trig_lo[0]
            && !r_reg.prev[0] && raw[0] |=> r_reg.sticky[0];
    endproperty
    a_rise: assert property (p_rise)
        else $error("rising edge not caught on bit 0");

    property p_level;
        @(posedge clk_i) disable iff (rst_i)
        !r_reg.trig_hi[5] && !r_reg.trig_lo[5] && raw[5]
            |=> r_reg.sticky[5];
    endproperty
    a_level: assert property (p_level)
        else $error("level trigger not caught on bit 5");

    property p_raw_read;
        @(posedge clk_i) disable iff (rst_i)
        take && !wb_we_i && wb_adr_i == OFS_RAW
            |=> wb_ack_o && wb_dat_o == $past(raw[31:0]);
    endproperty
    a_raw_read: assert property (p_raw_read)
        else $error("raw read does not show corrected input");

    property p_ident_read;
        @(posedge clk_i) disable iff (rst_i)
        take && !wb_we_i && wb_adr_i == OFS_IDENT
            |=> wb_dat_o == $past(r_reg.sticky[31:0] & r_reg.enable[31:0]);
    endproperty
    a_ident_read: assert property (p_ident_read)
        else $error("identity read is not sticky and enable");

    property p_led_gate;
        @(posedge clk_i) disable iff (rst_i)
        !env[0] && !r_reg.act_pol[0] |=> !led_o[0];
    endproperty
    a_led_gate: assert property (p_led_gate)
        else $error("activity led lit outside the envelope");

    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held for more than one cycle");

    c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
    c_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        $fell(irq_o));
    c_led: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(led_o[0]));
    c_map: cover property (@(posedge clk_i) disable iff (rst_i)
        r_reg.sd_cfg[SD_MAP_BIT] && |los_o.serdes);
endmodule : sgact_top

// >>> verification/sgact_chain_model.sv
// model of the board shift-register chain feeding sampled bursts
`timescale 1ns/1ps
module sgact_chain_model (
    input wire logic clk_i,
    output logic [127:0] bits_o,
    output logic burst_o
);
    initial begin
        bits_o = 128'h0;
        burst_o = 1'b0;
    end
    // one burst: parallel outputs hold between loads, done pulses once
    task automatic shift_in(input logic [127:0] v);
        @(posedge clk_i);
        bits_o <= v;
        burst_o <= 1'b1;
        @(posedge clk_i);
        burst_o <= 1'b0;
    endtask : shift_in
endmodule : sgact_chain_model

// >>> verification/sgact_top_tb.sv
// self-checking bench: registers, interrupts, loss forwarding, activity
`timescale 1ns/1ps
module sgact_top_tb;
    import sgact_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic blink0 = 1'b1;
    logic blink1 = 1'b0;
    logic [3:0] sel = 4'hF;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic ack_o;
    logic irq_o;
    logic bdone;
    logic [NBITS-1:0] bits;
    logic [NMODS-1:0] act = 65'h0;
    logic [NMODS-1:0] pgsel = 65'h0;
    logic [NPORTS-1:0] led_o;
    sgact_los_s los_o;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    sgact_chain_model chain (.clk_i(clk_i), .bits_o(bits), .burst_o(bdone));
    // short tick keeps the envelope at 202 cycles
    sgact_top #(.TICK_CYCLES(2)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack_o), .input_bits_i(bits),
        .burst_done_i(bdone), .blink0_i(blink0), .blink1_i(blink1),
        .act_pulse_i(act), .pgpio_los_sel_i(pgsel), .led_o(led_o),
        .irq_o(irq_o), .los_o(los_o));

    always #5 clk_i = ~clk_i;

    // hang guard: a wait that never ends counts as a mismatch
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rdat = dat_o;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask : bus

    task automatic chk(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rdchk(input string n, input logic [11:0] a,
                         input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rdat);
    endtask : rdchk

    // one-cycle activity pulse from port module 0
    task automatic pulse();
        @(posedge clk_i);
        act[0] <= 1'b1;
        @(posedge clk_i);
        act[0] <= 1'b0;
    endtask : pulse

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("sticky", OFS_STICKY, 32'h0);
        rdchk("unmapped", 12'hFFC, UNMAPPED_READ);
        // only the enabled byte lane may land
        sel <= 4'h1;
        bus(1'b1, OFS_ENABLE, 32'hFFFF_FFFF);
        sel <= 4'hF;
        rdchk("enable lanes", OFS_ENABLE, 32'h0000_00FF);
        bus(1'b1, OFS_TRIG_LO, 32'h1);
        bus(1'b1, OFS_TRIG_HI, 32'h1);
        bus(1'b1, OFS_ENABLE, 32'h1);
        chain.shift_in(128'h1);
        repeat (3) @(posedge clk_i);
        chk("irq", 32'h1, {31'h0, irq_o});
        rdchk("raw", OFS_RAW, 32'h1);
        rdchk("ident", OFS_IDENT, 32'h1);
        bus(1'b1, OFS_STICKY, 32'h0);
        rdchk("sticky", OFS_STICKY, 32'h1);
        rdchk("ident", OFS_IDENT, 32'h1);
        bus(1'b1, OFS_STICKY, 32'h1);
        rdchk("sticky", OFS_STICKY, 32'h0);
        chk("irq", 32'h0, {31'h0, irq_o});
        // a steady high input gives no new rising edge
        chain.shift_in(128'h1);
        rdchk("sticky", OFS_STICKY, 32'h0);
        chk("los", 32'h1, {31'h0, los_o.port[0]});
        // custom map: module 2 reads input 1, serdes 3 reads input 1
        bus(1'b1, OFS_PMAP + 12'h008, 32'h1);
        bus(1'b1, OFS_SMAP + 12'h00C, 32'h1);
        rdchk("pmap", OFS_PMAP + 12'h008, 32'h1);
        pgsel <= 65'h8;
        bus(1'b1, OFS_SD_CFG, 32'h2);
        @(posedge clk_i);
        chk("los map", 32'h33, {26'h0, los_o.port[5:0]});
        chk("serdes", 32'hF7, {24'h0, los_o.serdes});
        pgsel <= 65'h0;
        bus(1'b1, OFS_SD_CFG, 32'h0);
        bus(1'b1, OFS_POL, 32'h1);
        rdchk("raw", OFS_RAW, 32'h0);
        chk("los", 32'h0, {31'h0, los_o.port[0]});
        bus(1'b1, OFS_POL, 32'h0);
        chain.shift_in(128'h0);
        chain.shift_in(128'h1);
        repeat (3) @(posedge clk_i);
        chk("irq", 32'h1, {31'h0, irq_o});
        bus(1'b1, OFS_ENABLE, 32'h0);
        rdchk("ident", OFS_IDENT, 32'h0);
        chk("irq", 32'h0, {31'h0, irq_o});
        // envelope: still lit 190 cycles after a pulse, restarted by a second pulse
        pulse();
        repeat (190) @(posedge clk_i);
        chk("led", 32'h1, {31'h0, led_o[0]});
        blink0 <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("led", 32'h0, {31'h0, led_o[0]});
        blink0 <= 1'b1;
        pulse();
        repeat (180) @(posedge clk_i);
        chk("led", 32'h1, {31'h0, led_o[0]});
        // second generator selected while the envelope still stands
        bus(1'b1, OFS_ACT_SEL, 32'h1);
        @(posedge clk_i);
        chk("led", 32'h0, {31'h0, led_o[0]});
        blink1 <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("led", 32'h1, {31'h0, led_o[0]});
        repeat (30) @(posedge clk_i);
        chk("led", 32'h0, {31'h0, led_o[0]});
        bus(1'b1, OFS_ACT_POL, 32'h1);
        repeat (3) @(posedge clk_i);
        chk("led", 32'h1, {31'h0, led_o[0]});
        close_out();
    end
endmodule : sgact_top_tb
